/* hdl/frwh_ctrl.v */
/*
 * wake handshake and fault reaction control of a half-bridge driver
 * assumes trip inputs already deglitched in the analog front end;
 * pins and supply monitors are asynchronous and synchronised here
 */
//
// Overview of operation
// - internal regulator undervoltage holds power-on reset
// - SPI external-supply variant uses logic supply monitor
// - fault indicator low after wake or reset
// - acknowledgement releases indicator, enters standby
// - confirmed overcurrent disables output, indicator low
// - retry setting re-enables after retry interval
// - retry repeats while short persists, indicator low
// - fault-free retry keeps output enabled
// - overcurrent auto-clear after fault-free interval
// - thermal auto-clear after longer fault-free interval
// - thermal retry waits for cooling hysteresis
// - serial fault status latched until clear command
// - latch setting waits for acknowledgement or a drive enable drop to resume
// - current mirror clamped high on high-side short
`timescale 1ns/1ps
`include "frwh_regs.vh"
module frwh_ctrl #(
    parameter TW         = 18,
    parameter RETRY_CYC  = `FRWH_RETRY_CYC,
    parameter CLR_OC_CYC = `FRWH_CLR_OC_CYC,
    parameter CLR_TS_CYC = `FRWH_CLR_TS_CYC
) (
    // clock and reset
    input  wire ref_clk_i,
    input  wire sys_rst_i,
    input  wire clk_en_i,
    // variant straps
    input  wire spi_variant_i,
    input  wire ext_supply_i,
    input  wire retry_mode_i,
    // supply monitors, high while in undervoltage
    input  wire reg_uv_i,
    input  wire logic_uv_i,
    // controller side
    input  wire wake_request_pin_i,
    input  wire fault_clear_command_i,
    input  wire drive_enable_i,
    // protection comparators
    input  wire overcurrent_trip_i,
    input  wire hs_short_gnd_i,
    input  wire thermal_shutdown_trip_i,
    input  wire thermal_cooled_i,
    // outputs
    output wire fault_indicator_o,
    output wire fault_indicator_oe_o,
    output reg  output_enable_o,
    output reg  current_mirror_clamp_o,
    output reg  fault_status_o,
    output wire por_active_o,
    output wire [2:0] state_o
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers
localparam NS = 9;
reg  [NS-1:0] s1_reg;
reg  [NS-1:0] s2_reg;
wire [NS-1:0] raw = {reg_uv_i, logic_uv_i, wake_request_pin_i,
                     fault_clear_command_i, drive_enable_i,
                     overcurrent_trip_i, hs_short_gnd_i,
                     thermal_shutdown_trip_i, thermal_cooled_i};

always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
        // hold power-on reset until the monitors are really sampled
        s1_reg <= `FRWH_SYNC_RST;
        s2_reg <= `FRWH_SYNC_RST;
    end else if (clk_en_i) begin
        s1_reg <= raw;
        s2_reg <= s1_reg;
    end
end

wire reg_uv  = s2_reg[8];
wire log_uv  = s2_reg[7];
wire wake    = s2_reg[6];
wire clr_cmd = s2_reg[5];
wire drv_en  = s2_reg[4];
wire oc      = s2_reg[3];
wire hs_gnd  = s2_reg[2];
wire thermal_shutdown_trip     = s2_reg[1];
wire cooled  = s2_reg[0];

////////////////////////////////////////////////////////////////////////////////
// edge detection and acknowledgement
reg wake_d_reg;
reg clr_d_reg;
reg pulse_low_reg;
reg [7:0] low_cnt_reg;

always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
        wake_d_reg    <= 1'b0;
        clr_d_reg     <= 1'b0;
        pulse_low_reg <= 1'b0;
        low_cnt_reg   <= 8'h00;
    end else if (clk_en_i) begin
        wake_d_reg    <= wake;
        clr_d_reg     <= clr_cmd;
        // a low lasting past the limit is sleep, not a pulse
        if (wake) begin
            pulse_low_reg <= 1'b0;
            low_cnt_reg   <= 8'h00;
        end else if (wake_d_reg) begin
            pulse_low_reg <= 1'b1;
            low_cnt_reg   <= 8'h00;
        end else if (pulse_low_reg) begin
            if (low_cnt_reg == `FRWH_PULSE_MAX_CYC)
                pulse_low_reg <= 1'b0;
            else
                low_cnt_reg <= low_cnt_reg + 8'h01;
        end
    end
end

wire wake_rise  = wake && !wake_d_reg;
wire pulse_done = wake_rise && pulse_low_reg;
wire clr_rise   = clr_cmd && !clr_d_reg;
// acknowledgement by variant
wire ack = spi_variant_i ? clr_rise : pulse_done;

// power-on reset source per variant
wire por = (spi_variant_i && ext_supply_i) ? log_uv
                                           : reg_uv;
assign por_active_o = por;

// sleep applies only where a wake pin exists
wire sleeping = !(spi_variant_i && ext_supply_i) && !wake && !wake_d_reg &&
                !pulse_low_reg;

////////////////////////////////////////////////////////////////////////////////
// timers
reg          rt_load;
reg          cl_load;
reg          tsd_ev_reg;
reg [2:0]    st_reg;
reg [2:0]    st_next;
wire         rt_done;
wire         cl_done;

function [TW-1:0] cyc;
    input integer n;
    begin
        cyc = n[TW-1:0];
    end
endfunction

frwh_timer #(.W(TW)) u_retry (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .load_i    (rt_load),
    .count_i   (cyc(RETRY_CYC)),
    .run_i     (1'b1),
    .done_o    (rt_done)
);

frwh_timer #(.W(TW)) u_clear (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .load_i    (cl_load),
    .count_i   (tsd_ev_reg ? cyc(CLR_TS_CYC)
                           : cyc(CLR_OC_CYC)),
    .run_i     (st_reg == `FRWH_ST_RETRY_ON ||
                st_reg == `FRWH_ST_STANDBY),
    .done_o    (cl_done)
);

////////////////////////////////////////////////////////////////////////////////
// state machine
reg  flt_low_reg;
reg  flt_low_next;
wire trip = oc || thermal_shutdown_trip;

always @* begin
    st_next      = st_reg;
    flt_low_next = flt_low_reg;
    rt_load      = 1'b0;
    cl_load      = 1'b0;
    case (st_reg)
        `FRWH_ST_POR: begin
            if (!por) begin
                st_next      = `FRWH_ST_WAKE_ACK;
                flt_low_next = 1'b1;
            end
        end
        `FRWH_ST_SLEEP: begin
            flt_low_next = 1'b0;
            if (wake_rise) begin
                st_next      = `FRWH_ST_WAKE_ACK;
                flt_low_next = 1'b1;
            end
        end
        `FRWH_ST_WAKE_ACK: begin
            if (ack) begin
                st_next      = `FRWH_ST_STANDBY;
                flt_low_next = 1'b0;
            end
        end
        `FRWH_ST_STANDBY: begin
            if (trip && drv_en) begin
                st_next      = `FRWH_ST_FAULT_OFF;
                flt_low_next = 1'b1;
                rt_load      = 1'b1;
            end else if (ack || (retry_mode_i && cl_done)) begin
                flt_low_next = 1'b0;
            end
        end
        `FRWH_ST_FAULT_OFF: begin
            if (!drv_en) begin
                // indicator stays low until auto-clear or acknowledge
                st_next      = `FRWH_ST_STANDBY;
                cl_load      = retry_mode_i;
            end else if (!retry_mode_i) begin
                if (ack) begin
                    st_next      = `FRWH_ST_RETRY_ON;
                    flt_low_next = 1'b0;
                    cl_load      = 1'b1;
                end
            end else if (tsd_ev_reg ? cooled : rt_done) begin
                st_next = `FRWH_ST_RETRY_ON;
                cl_load = 1'b1;
            end
        end
        `FRWH_ST_RETRY_ON: begin
            if (trip) begin
                st_next      = `FRWH_ST_FAULT_OFF;
                flt_low_next = 1'b1;
                rt_load      = 1'b1;
            end else if (cl_done) begin
                st_next      = `FRWH_ST_STANDBY;
                flt_low_next = 1'b0;
            end else if (!drv_en) begin
                st_next = `FRWH_ST_STANDBY;
            end
        end
        default: st_next = `FRWH_ST_POR;
    endcase
    if (por) begin
        st_next      = `FRWH_ST_POR;
        flt_low_next = 1'b0;
    end else if (sleeping && st_reg != `FRWH_ST_POR) begin
        st_next      = `FRWH_ST_SLEEP;
        flt_low_next = 1'b0;
    end
end

always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
        st_reg                 <= `FRWH_ST_POR;
        flt_low_reg            <= 1'b0;
        tsd_ev_reg             <= 1'b0;
        output_enable_o        <= 1'b0;
        current_mirror_clamp_o <= 1'b0;
        fault_status_o         <= 1'b0;
    end else if (clk_en_i) begin
        st_reg      <= st_next;
        flt_low_reg <= flt_low_next;
        if (trip && st_next == `FRWH_ST_FAULT_OFF &&
            st_reg != `FRWH_ST_FAULT_OFF)
            tsd_ev_reg <= thermal_shutdown_trip;
        output_enable_o <= drv_en && (st_next == `FRWH_ST_STANDBY ||
                                      st_next == `FRWH_ST_RETRY_ON);
        // clamp marks a high-side short to ground while off
        if (st_next == `FRWH_ST_FAULT_OFF && hs_gnd && oc)
            current_mirror_clamp_o <= 1'b1;
        else if (st_next != `FRWH_ST_FAULT_OFF)
            current_mirror_clamp_o <= 1'b0;
        // set wins over clear
        if (trip && drv_en)
            fault_status_o <= 1'b1;
        else if (clr_rise || (!spi_variant_i && flt_low_next == 1'b0))
            fault_status_o <= 1'b0;
    end
end

// open-drain: drive only low
assign fault_indicator_o    = 1'b0;
assign fault_indicator_oe_o = flt_low_reg;
assign state_o              = st_reg;

endmodule

/* hdl/frwh_regs.vh */
/*
 * constants of the fault reaction and wake handshake block
 * assumes a 40 MHz reference clock
 */
`ifndef FRWH_REGS_VH
`define FRWH_REGS_VH

// clock period in nanoseconds
`define FRWH_CLK_NS        25
// retry interval, least 4.1 ms, longest 6.1 ms (in us)
`define FRWH_RETRY_MIN_US  4100
// auto-clear after overcurrent, least 85 us, longest 200 us
`define FRWH_CLR_OC_MIN_US 85
// auto-clear after thermal trip, least 4.2 ms, longest 6.7 ms (in us)
`define FRWH_CLR_TS_MIN_US 4200
// cycle counts, least times rounded up
`define FRWH_CYC(us) (((us) * 1000 + `FRWH_CLK_NS - 1) / `FRWH_CLK_NS)
`define FRWH_RETRY_CYC     `FRWH_CYC(`FRWH_RETRY_MIN_US)
`define FRWH_CLR_OC_CYC    `FRWH_CYC(`FRWH_CLR_OC_MIN_US)
`define FRWH_CLR_TS_CYC    `FRWH_CYC(`FRWH_CLR_TS_MIN_US)

// handshake states
`define FRWH_ST_POR        3'h0
`define FRWH_ST_SLEEP      3'h1
`define FRWH_ST_WAKE_ACK   3'h2
`define FRWH_ST_STANDBY    3'h3
`define FRWH_ST_FAULT_OFF  3'h4
`define FRWH_ST_RETRY_ON   3'h5

// synchroniser reset: both supply monitors read as undervoltage
`define FRWH_SYNC_RST      9'h180
// longest wake pin low time taken as a reset pulse, chosen value
`define FRWH_PULSE_MAX_CYC 8'hc8

`endif

/* hdl/frwh_timer.v */
/*
 * down-counting interval timer with load and expiry pulse
 * assumes one clock, synchronous active-high reset
 */
`timescale 1ns/1ps
module frwh_timer #(
    parameter W = 20
) (
    // clock and reset
    input  wire         ref_clk_i,
    input  wire         sys_rst_i,
    input  wire         clk_en_i,
    // control
    input  wire         load_i,
    input  wire [W-1:0] count_i,
    input  wire         run_i,
    // status
    output wire         done_o
);

reg [W-1:0] cnt_reg;
reg         armed_reg;

always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
        cnt_reg   <= {W{1'b0}};
        armed_reg <= 1'b0;
    end else if (clk_en_i) begin
        if (load_i) begin
            cnt_reg   <= count_i;
            armed_reg <= 1'b1;
        end else if (armed_reg && run_i) begin
            if (cnt_reg == {{(W-1){1'b0}}, 1'b1})
                armed_reg <= 1'b0;
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end
end

assign done_o = armed_reg && run_i && !load_i &&
                (cnt_reg == {{(W-1){1'b0}}, 1'b1});

endmodule

/* bench/frwh_ctrl_assertions.sv */
/* checker of the wake handshake and fault reaction control
   assumes binding to frwh_ctrl, one clock, sync reset */
`timescale 1ns/1ps
module frwh_ctrl_chk #(
    parameter RETRY_CYC  = 20,
    parameter CLR_OC_CYC = 8,
    parameter CLR_TS_CYC = 12
) (
    input wire       ref_clk_i,
    input wire       sys_rst_i,
    input wire       retry_mode_i,
    input wire       thermal_cooled_i,
    input wire       fault_indicator_oe_o,
    input wire       output_enable_o,
    input wire       current_mirror_clamp_o,
    input wire       por_active_o,
    input wire [2:0] state_o
);
    logic [2:0]  prev_st_reg;
    logic [19:0] dwell_reg;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // cycles spent in the current state
    always @(posedge ref_clk_i) begin
        prev_st_reg <= state_o;
        dwell_reg   <= (sys_rst_i || state_o != prev_st_reg) ? 20'h0
                       : dwell_reg + 20'h1;
    end
    chk_por_hold:
        assert property (por_active_o [*2] |-> state_o == 3'h0
            && !output_enable_o) else $error("state left por early");
    chk_wake_low:
        assert property (state_o == 3'h2 && prev_st_reg == 3'h2
            |-> fault_indicator_oe_o) else $error("no wake indication");
    chk_ack_release:
        assert property (prev_st_reg == 3'h2 && state_o == 3'h3
            |-> ##[0:1] !fault_indicator_oe_o) else $error("not released");
    chk_off_holds:
        assert property (state_o == 3'h4 && prev_st_reg == 3'h4
            |-> !output_enable_o && fault_indicator_oe_o)
        else $error("output on while off");
    chk_retry_time:
        assert property (prev_st_reg == 3'h4 && state_o == 3'h5
            && retry_mode_i && !thermal_cooled_i
            |-> dwell_reg >= RETRY_CYC - 2 && dwell_reg <= RETRY_CYC + 4)
        else $error("retry interval wrong");
    chk_retry_low:
        assert property (state_o == 3'h5 && prev_st_reg == 3'h5
            && retry_mode_i |-> fault_indicator_oe_o)
        else $error("indicator released during retry");
    chk_retry_on:
        assert property (state_o == 3'h5 && prev_st_reg == 3'h5
            |-> output_enable_o) else $error("output off in retry");
    chk_oc_clear:
        assert property (prev_st_reg == 3'h5 && state_o == 3'h3
            && retry_mode_i |-> dwell_reg >= CLR_OC_CYC - 2)
        else $error("overcurrent clear too early");
    chk_ts_clear:
        assert property (prev_st_reg == 3'h5 && state_o == 3'h3
            && retry_mode_i && thermal_cooled_i
            |-> dwell_reg >= CLR_TS_CYC - 2) else $error("thermal clear early");
    chk_clamp_off:
        assert property (current_mirror_clamp_o && $past(current_mirror_clamp_o)
            |-> !output_enable_o) else $error("clamp with output on");
    cover property (prev_st_reg == 3'h4 && state_o == 3'h5);
    cover property (prev_st_reg == 3'h5 && state_o == 3'h3);
    cover property (prev_st_reg == 3'h2 && state_o == 3'h3);
endmodule
bind frwh_ctrl frwh_ctrl_chk #(.RETRY_CYC(RETRY_CYC),
    .CLR_OC_CYC(CLR_OC_CYC), .CLR_TS_CYC(CLR_TS_CYC)) u_chk (
    .ref_clk_i              (ref_clk_i),
    .sys_rst_i              (sys_rst_i),
    .retry_mode_i           (retry_mode_i),
    .thermal_cooled_i       (thermal_cooled_i),
    .fault_indicator_oe_o   (fault_indicator_oe_o),
    .output_enable_o        (output_enable_o),
    .current_mirror_clamp_o (current_mirror_clamp_o),
    .por_active_o           (por_active_o),
    .state_o                (state_o)
);

/* bench/frwh_mcu_model.sv */
/* controller model: wake pin level, acknowledge pulse or clear edge
   assumes fault pin level resolved with pull-up by the bench */
`timescale 1ns/1ps
module frwh_mcu_model (
    input  wire       clk_i,
    input  wire       spi_i,
    input  wire       awake_i,
    input  wire       ack_i,
    input  wire [7:0] dly_i,
    input  wire       fault_n_i,
    output logic      wake_o,
    output logic      clr_o
);
    initial begin
        wake_o = 1'b0;
        clr_o  = 1'b0;
    end
    always begin
        @(posedge clk_i);
        if (!(ack_i && (spi_i || !fault_n_i))) begin
            wake_o <= awake_i;
        end else begin
            repeat (dly_i) @(posedge clk_i);
            if (spi_i) clr_o <= 1'b1;
            else wake_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            clr_o  <= 1'b0;
            wake_o <= awake_i;
        end
    end
endmodule

/* bench/tb_frwh_ctrl.sv */
/* bench of the wake handshake and fault reaction control
   assumes 40 MHz clock, shortened interval parameters */
`timescale 1ns/1ps
module tb_frwh_ctrl;
    logic ref_clk_i, sys_rst_i, clk_en_i, spi_variant_i, ext_supply_i;
    logic retry_mode_i, reg_uv_i, logic_uv_i, drive_enable_i, awake, ack;
    logic overcurrent_trip_i, hs_short_gnd_i, thermal_shutdown_trip_i;
    logic thermal_cooled_i;
    logic [7:0] dly;
    wire wake_request_pin_i, fault_clear_command_i, fault_indicator_o;
    wire fault_indicator_oe_o, output_enable_o, current_mirror_clamp_o;
    wire fault_status_o, por_active_o;
    wire [2:0] state_o;
    wire fault_n = fault_indicator_oe_o ? fault_indicator_o : 1'b1;
    logic [2:0] exp_q[$];
    logic [2:0] last;
    int miscompares, total_checks;
    frwh_ctrl #(.RETRY_CYC(20), .CLR_OC_CYC(8), .CLR_TS_CYC(12)) uut (
        .ref_clk_i               (ref_clk_i),
        .sys_rst_i               (sys_rst_i),
        .clk_en_i                (clk_en_i),
        .spi_variant_i           (spi_variant_i),
        .ext_supply_i            (ext_supply_i),
        .retry_mode_i            (retry_mode_i),
        .reg_uv_i                (reg_uv_i),
        .logic_uv_i              (logic_uv_i),
        .wake_request_pin_i      (wake_request_pin_i),
        .fault_clear_command_i   (fault_clear_command_i),
        .drive_enable_i          (drive_enable_i),
        .overcurrent_trip_i      (overcurrent_trip_i),
        .hs_short_gnd_i          (hs_short_gnd_i),
        .thermal_shutdown_trip_i (thermal_shutdown_trip_i),
        .thermal_cooled_i        (thermal_cooled_i),
        .fault_indicator_o       (fault_indicator_o),
        .fault_indicator_oe_o    (fault_indicator_oe_o),
        .output_enable_o         (output_enable_o),
        .current_mirror_clamp_o  (current_mirror_clamp_o),
        .fault_status_o          (fault_status_o),
        .por_active_o            (por_active_o),
        .state_o                 (state_o)
    );
    frwh_mcu_model mcu (.clk_i(ref_clk_i), .spi_i(spi_variant_i),
        .awake_i(awake), .ack_i(ack), .dly_i(dly), .fault_n_i(fault_n),
        .wake_o(wake_request_pin_i), .clr_o(fault_clear_command_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task check(input logic [2:0] e, input logic [2:0] a);
        total_checks++;
        if (e !== a) begin
            miscompares++;
            $display("unexpected at %0t: expected %h got %h", $time, e, a);
        end
    endtask
    task stop_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task wait_st(input logic [2:0] s);
        for (int i = 0; i < 400 && state_o !== s; i++) @(negedge ref_clk_i);
        if (state_o !== s) miscompares++;
        tick(1);
    endtask
    task do_ack;
        dly <= 8'($urandom % 16);
        ack <= 1'b1;
        tick(1);
        ack <= 1'b0;
    endtask
    task rst(input logic spi, input logic ext, input logic rty);
        sys_rst_i <= 1'b1;
        spi_variant_i <= spi;
        ext_supply_i <= ext;
        retry_mode_i <= rty;
        {reg_uv_i, logic_uv_i, awake, ack} <= 4'he;
        {drive_enable_i, overcurrent_trip_i, hs_short_gnd_i} <= 3'h0;
        {thermal_shutdown_trip_i, thermal_cooled_i} <= 2'h0;
        tick(20);
        sys_rst_i <= 1'b0;
        tick(5);
    endtask
    // compare each state change against the oldest expectation
    always @(posedge ref_clk_i)
        if (sys_rst_i) last = 3'h0;
        else if (state_o !== last) begin
            last = state_o;
            if (exp_q.size() == 0) check(3'h7, state_o);
            else check(exp_q.pop_front(), state_o);
        end
    initial begin
        #1000000;
        miscompares++;
        stop_test;
    end
    initial begin
        clk_en_i = 1'b1;
        dly = 8'h00;
        void'($urandom(12));
        rst(1'b0, 1'b0, 1'b1);
        check(3'h1, {2'h0, por_active_o});
        exp_q = {exp_q, 3'h2, 3'h3};
        reg_uv_i <= 1'b0;
        wait_st(3'h2);
        check(3'h0, {2'h0, fault_n});
        do_ack;
        wait_st(3'h3);
        {drive_enable_i, hs_short_gnd_i, overcurrent_trip_i} <= 3'h7;
        exp_q = {exp_q, 3'h4, 3'h5, 3'h4};
        wait_st(3'h4);
        tick(3);
        check(3'h1, {2'h0, current_mirror_clamp_o});
        wait_st(3'h5);
        wait_st(3'h4);
        {hs_short_gnd_i, overcurrent_trip_i} <= 2'h0;
        exp_q = {exp_q, 3'h5, 3'h3};
        wait_st(3'h3);
        check(3'h1, {2'h0, fault_n});
        rst(1'b1, 1'b0, 1'b0);
        exp_q = {exp_q, 3'h2, 3'h3, 3'h4};
        reg_uv_i <= 1'b0;
        wait_st(3'h2);
        do_ack;
        wait_st(3'h3);
        {drive_enable_i, overcurrent_trip_i} <= 2'h3;
        wait_st(3'h4);
        tick(60);
        check(3'h0, {2'h0, output_enable_o});
        check(3'h0, {2'h0, fault_n});
        overcurrent_trip_i <= 1'b0;
        exp_q = {exp_q, 3'h5};
        do_ack;
        wait_st(3'h5);
        tick(2);
        check(3'h1, {2'h0, output_enable_o});
        check(3'h1, {2'h0, fault_n});
        rst(1'b1, 1'b1, 1'b1);
        check(3'h1, {2'h0, por_active_o});
        awake <= 1'b0;
        exp_q = {exp_q, 3'h2, 3'h3, 3'h4};
        logic_uv_i <= 1'b0;
        reg_uv_i <= 1'($urandom % 2);
        wait_st(3'h2);
        do_ack;
        wait_st(3'h3);
        {drive_enable_i, thermal_shutdown_trip_i} <= 2'h3;
        wait_st(3'h4);
        tick(40);
        {thermal_shutdown_trip_i, thermal_cooled_i} <= 2'h1;
        exp_q = {exp_q, 3'h5, 3'h3};
        wait_st(3'h3);
        check(3'h1, {2'h0, fault_status_o});
        do_ack;
        tick(30);
        check(3'h0, {2'h0, fault_status_o});
        if (exp_q.size() != 0) miscompares++;
        stop_test;
    end
endmodule
